// ### shared/sensor_power_regs.svh
// register offsets, field positions, reset values and timing counts of the power sequencer
`ifndef SENSOR_POWER_REGS_SVH
`define SENSOR_POWER_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define SPS_IDX_ENABLE      10'h080
`define SPS_IDX_STATUS4     10'h09f
`define SPS_IDX_CFG0        10'h0a1
`define SPS_IDX_CONTROL     10'h0b1
`define SPS_IDX_STATE_VIEW  10'h0f0

// ==========================================================
// field positions
`define SPS_EN_POWER_UP_BIT 0
`define SPS_EN_LIGHT_BIT    1
`define SPS_EN_FDEN_BIT     6
`define SPS_CFG0_IRQ_SLEEP_BIT 6
`define SPS_ST4_HOLD_BIT    0
`define SPS_CTL_HOLD_CLR_BIT 2

// ==========================================================
// reset values
`define SPS_ENABLE_RST      8'h00
`define SPS_CFG0_RST        8'h08

// ==========================================================
// timing
`define SPS_CLK_KHZ         40000
`define SPS_INIT_TIME_US    500
`define SPS_INIT_CYCLES     (`SPS_INIT_TIME_US * `SPS_CLK_KHZ / 1000)
`define SPS_OSC_KHZ         720
`define SPS_OSC_DIV         ((`SPS_CLK_KHZ + `SPS_OSC_KHZ - 1) / `SPS_OSC_KHZ)

`endif

// ### shared/sensor_power_pkg.sv
// types of the power sequencer
`default_nettype none

package sensor_power_pkg;

   typedef enum logic [2:0] {
      ST_INIT   = 3'h0,
      ST_SLEEP  = 3'h1,
      ST_IDLE   = 3'h3,
      ST_ACTIVE = 3'h2,
      ST_HOLD   = 3'h6
   } pwr_state_t;

   typedef struct packed {
      logic fden;
      logic light_sense_function_enable;
      logic power_up_request_bit;
   } enable_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } wr_req_t;

endpackage

`default_nettype wire

// ### design/sensor_power_state_sequencer.sv
// power state sequencer with axi4-lite registers and serial bus watcher
// Functional notes
// - nack every serial transfer during initialization
// - after initialization enter sleep, oscillator stopped
// - bus start wakes bus interface until stop
// - power-up bit moves sleep to idle, oscillator on
// - function enable leaves idle; all cleared returns
// - light and flicker sampling run concurrently
// - sleep-after-irq bit forces sleep on interrupt
// - forced sleep leaves all register settings unchanged
// - forced sleep holds until host clears flag
// - oscillator tick at about 720 khz
// - plain sleep when power-up bit is zero, outside initialization and forced sleep
`include "sensor_power_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module sensor_power_state_sequencer #(
   parameter int unsigned INIT_CYCLES = `SPS_INIT_CYCLES
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_nrst,
   // axi4-lite write
   input  wire logic [11:0] i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output var  logic        o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output var  logic        o_s_axi_wready,
   output var  logic [1:0]  o_s_axi_bresp,
   output var  logic        o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output var  logic        o_s_axi_arready,
   output var  logic [31:0] o_s_axi_rdata,
   output var  logic [1:0]  o_s_axi_rresp,
   output var  logic        o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready,
   // serial bus pins
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output var  logic        o_sda_out,
   output var  logic        o_sda_oe,
   // measurement side
   input  wire logic        i_irq_event,
   output var  logic        o_init_busy,
   output var  logic        o_bus_if_awake,
   output var  logic        o_osc_run,
   output var  logic        o_osc_tick,
   output var  logic        o_als_run,
   output var  logic        o_flicker_run
);

   // ==========================================================
   // declarations
   sensor_power_pkg::pwr_state_t state_reg, state_next;
   sensor_power_pkg::enable_t    en_reg;
   sensor_power_pkg::wr_req_t    wr_reg;
   logic [7:0]  cfg0_reg;
   logic        hold_flag_reg;
   logic [31:0] init_cnt_reg;
   logic [5:0]  osc_cnt_reg;
   logic        aw_got_reg;
   logic        w_got_reg;
   logic [2:0]  scl_sync_reg;
   logic [2:0]  sda_sync_reg;
   logic        bus_busy_reg;

   function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
      idx_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   // ==========================================================
   // decoding
   wire       do_write   = aw_got_reg && w_got_reg && !o_s_axi_bvalid;
   wire       lane0      = wr_reg.strb[0];
   wire       wr_enable  = idx_hit(wr_reg.addr, `SPS_IDX_ENABLE);
   wire       wr_cfg0    = idx_hit(wr_reg.addr, `SPS_IDX_CFG0);
   wire       wr_control = idx_hit(wr_reg.addr, `SPS_IDX_CONTROL);
   wire       wr_mapped  = wr_enable || wr_cfg0 || wr_control || idx_hit(wr_reg.addr, `SPS_IDX_STATUS4)
                           || idx_hit(wr_reg.addr, `SPS_IDX_STATE_VIEW);
   wire       pwr_up     = en_reg.power_up_request_bit;
   wire       light_en   = en_reg.light_sense_function_enable;
   wire       sleep_after_irq_enable = cfg0_reg[`SPS_CFG0_IRQ_SLEEP_BIT];
   wire       any_func   = light_en || en_reg.fden;
   wire       running    = (state_reg == sensor_power_pkg::ST_IDLE) || (state_reg == sensor_power_pkg::ST_ACTIVE);
   wire       irq_sleep  = running && sleep_after_irq_enable && i_irq_event;
   wire       hold_clr   = do_write && lane0 && wr_control && wr_reg.data[`SPS_CTL_HOLD_CLR_BIT];
   wire       hold_next  = irq_sleep || (hold_flag_reg && !hold_clr);
   wire       init_done  = init_cnt_reg == 32'(INIT_CYCLES - 1);
   wire       osc_wrap   = osc_cnt_reg == 6'(`SPS_OSC_DIV - 1);
   wire       run_next   = (state_next == sensor_power_pkg::ST_IDLE) || (state_next == sensor_power_pkg::ST_ACTIVE);
   wire       start_det  = scl_sync_reg[1] && sda_sync_reg[2] && !sda_sync_reg[1];
   wire       stop_det   = scl_sync_reg[1] && !sda_sync_reg[2] && sda_sync_reg[1];
   wire [7:0] enable_rd  = {1'b0, en_reg.fden, 4'h0, light_en, pwr_up};
   wire [31:0] rd_word   = idx_hit(i_s_axi_araddr, `SPS_IDX_ENABLE)     ? {24'h0, enable_rd} :
                           idx_hit(i_s_axi_araddr, `SPS_IDX_CFG0)       ? {24'h0, cfg0_reg} :
                           idx_hit(i_s_axi_araddr, `SPS_IDX_STATUS4)    ? {31'h0, hold_flag_reg} :
                           idx_hit(i_s_axi_araddr, `SPS_IDX_STATE_VIEW) ? {28'h0, o_osc_run, state_reg} :
                           32'h0;
   wire       rd_mapped  = idx_hit(i_s_axi_araddr, `SPS_IDX_ENABLE) || idx_hit(i_s_axi_araddr, `SPS_IDX_CFG0)
                           || idx_hit(i_s_axi_araddr, `SPS_IDX_STATUS4) || idx_hit(i_s_axi_araddr, `SPS_IDX_CONTROL)
                           || idx_hit(i_s_axi_araddr, `SPS_IDX_STATE_VIEW);

   // ==========================================================
   // state machine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         sensor_power_pkg::ST_INIT: begin
            if (init_done) state_next = sensor_power_pkg::ST_SLEEP;
         end
         sensor_power_pkg::ST_SLEEP: begin
            if (pwr_up) state_next = sensor_power_pkg::ST_IDLE;
         end
         sensor_power_pkg::ST_IDLE: begin
            if (irq_sleep) state_next = sensor_power_pkg::ST_HOLD;
            else if (!pwr_up) state_next = sensor_power_pkg::ST_SLEEP;
            else if (any_func) state_next = sensor_power_pkg::ST_ACTIVE;
         end
         sensor_power_pkg::ST_ACTIVE: begin
            if (irq_sleep) state_next = sensor_power_pkg::ST_HOLD;
            else if (!pwr_up) state_next = sensor_power_pkg::ST_SLEEP;
            else if (!any_func) state_next = sensor_power_pkg::ST_IDLE;
         end
         sensor_power_pkg::ST_HOLD: begin
            if (!hold_flag_reg) begin
               state_next = pwr_up ? sensor_power_pkg::ST_IDLE : sensor_power_pkg::ST_SLEEP;
            end
         end
         default: state_next = sensor_power_pkg::ST_SLEEP;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state_reg     <= sensor_power_pkg::ST_INIT;
         init_cnt_reg  <= 32'h0;
         hold_flag_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         init_cnt_reg  <= init_done ? init_cnt_reg : init_cnt_reg + 32'h1;
         hold_flag_reg <= hold_next;
      end
   end

   // ==========================================================
   // oscillator and function outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         osc_cnt_reg   <= 6'h0;
         o_osc_run     <= 1'b0;
         o_osc_tick    <= 1'b0;
         o_als_run     <= 1'b0;
         o_flicker_run <= 1'b0;
         o_init_busy   <= 1'b1;
      end else begin
         osc_cnt_reg   <= (!run_next || osc_wrap) ? 6'h0 : osc_cnt_reg + 6'h1;
         o_osc_run     <= run_next;
         o_osc_tick    <= run_next && osc_wrap;
         o_als_run     <= (state_next == sensor_power_pkg::ST_ACTIVE) && light_en;
         o_flicker_run <= (state_next == sensor_power_pkg::ST_ACTIVE) && en_reg.fden;
         o_init_busy   <= state_next == sensor_power_pkg::ST_INIT;
      end
   end

   // ==========================================================
   // serial bus watcher
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         scl_sync_reg   <= 3'h7;
         sda_sync_reg   <= 3'h7;
         bus_busy_reg   <= 1'b0;
         o_bus_if_awake <= 1'b0;
         o_sda_out      <= 1'b0;
         o_sda_oe       <= 1'b0;
      end else begin
         scl_sync_reg   <= {scl_sync_reg[1:0], i_scl};
         sda_sync_reg   <= {sda_sync_reg[1:0], i_sda};
         bus_busy_reg   <= (start_det || (bus_busy_reg && !stop_det)) && (state_reg != sensor_power_pkg::ST_INIT);
         o_bus_if_awake <= (start_det || (bus_busy_reg && !stop_det)) && (state_reg != sensor_power_pkg::ST_INIT);
         o_sda_out      <= 1'b0;
         o_sda_oe       <= 1'b0;
      end
   end

   // ==========================================================
   // axi4-lite slave
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready  <= 1'b1;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= 2'h0;
         aw_got_reg      <= 1'b0;
         w_got_reg       <= 1'b0;
         wr_reg          <= '0;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            o_s_axi_awready <= 1'b0;
            aw_got_reg      <= 1'b1;
            wr_reg.addr     <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            o_s_axi_wready <= 1'b0;
            w_got_reg      <= 1'b1;
            wr_reg.data    <= i_s_axi_wdata;
            wr_reg.strb    <= i_s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_reg     <= 1'b0;
            w_got_reg      <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= wr_mapped ? 2'h0 : 2'h2;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
         end
      end
   end

   // settings change only by software writes, never by the forced sleep
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         en_reg   <= '0;
         cfg0_reg <= `SPS_CFG0_RST;
      end else begin
         if (do_write && lane0 && wr_enable) begin
            en_reg.power_up_request_bit        <= wr_reg.data[`SPS_EN_POWER_UP_BIT];
            en_reg.light_sense_function_enable <= wr_reg.data[`SPS_EN_LIGHT_BIT];
            en_reg.fden                        <= wr_reg.data[`SPS_EN_FDEN_BIT];
         end
         if (do_write && lane0 && wr_cfg0) cfg0_reg <= wr_reg.data[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0;
         o_s_axi_rresp   <= 2'h0;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid  <= 1'b1;
         o_s_axi_rdata   <= rd_word;
         o_s_axi_rresp   <= rd_mapped ? 2'h0 : 2'h2;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   a_init_nack_only: assert property (o_init_busy |-> !o_sda_oe && !o_bus_if_awake)
      else $error("bus answered during initialization");
   a_init_then_sleep: assert property (state_reg == sensor_power_pkg::ST_INIT && init_done |=>
      state_reg == sensor_power_pkg::ST_SLEEP && !o_osc_run && !o_init_busy)
      else $error("initialization did not end in sleep");
   a_sleep_osc_off: assert property (state_reg == sensor_power_pkg::ST_SLEEP |-> !o_osc_run && !o_osc_tick)
      else $error("oscillator running in sleep");
   a_bus_wake_span: assert property (start_det && state_reg != sensor_power_pkg::ST_INIT |=> o_bus_if_awake)
      else $error("bus interface not woken by start");
   a_bus_wake_ends: assert property (stop_det |=> !o_bus_if_awake)
      else $error("bus interface awake after stop");
   a_power_up_idle: assert property (state_reg == sensor_power_pkg::ST_SLEEP && pwr_up |=>
      state_reg == sensor_power_pkg::ST_IDLE && o_osc_run)
      else $error("power-up did not reach idle");
   a_idle_leave: assert property (state_reg == sensor_power_pkg::ST_IDLE && pwr_up && light_en && !irq_sleep
      |=> state_reg == sensor_power_pkg::ST_ACTIVE)
      else $error("enable did not leave idle");
   a_idle_return: assert property (state_reg == sensor_power_pkg::ST_ACTIVE && pwr_up && !any_func
      && !irq_sleep |=> state_reg == sensor_power_pkg::ST_IDLE && !o_als_run && !o_flicker_run)
      else $error("cleared enables did not return to idle");
   a_concurrent_run: assert property (state_reg == sensor_power_pkg::ST_ACTIVE && pwr_up && light_en
      && en_reg.fden && !irq_sleep |=> o_als_run && o_flicker_run)
      else $error("functions not concurrent");
   a_irq_forces_sleep: assert property (irq_sleep |=> state_reg == sensor_power_pkg::ST_HOLD && hold_flag_reg
      && !o_osc_run)
      else $error("interrupt did not force sleep");
   a_hold_keeps_set: assert property ($rose(state_reg == sensor_power_pkg::ST_HOLD) |-> $stable(en_reg)
      && $stable(cfg0_reg))
      else $error("forced sleep changed settings");
   a_hold_until_clr: assert property (state_reg == sensor_power_pkg::ST_HOLD && hold_flag_reg |=>
      state_reg == sensor_power_pkg::ST_HOLD)
      else $error("forced sleep left before flag clear");
   a_osc_tick_gap: assert property (o_osc_tick |=> !o_osc_tick [*8])
      else $error("oscillator tick too fast");
   a_power_clear_sleep: assert property (running && !pwr_up && !irq_sleep |=>
      state_reg == sensor_power_pkg::ST_SLEEP)
      else $error("power-up clear did not sleep");

endmodule

`default_nettype wire

// ### dv/sps_i2c_host.sv
// i2c host model driving the serial bus pins of the sequencer
`timescale 1ns/100ps
`default_nettype none

module sps_i2c_host (
   // bus lines
   input  wire logic i_sda_line,
   output var  logic o_scl,
   output var  logic o_sda_oe
);
   // ==========================================================
   // idle: clock stands high, data released to the pull-up
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   // ==========================================================
   // one frame: start, one byte, ack slot, stop; 200 ns bit period
   task automatic frame(input logic [7:0] b, output logic acked);
      #7;
      o_sda_oe = 1'b1;
      #600;
      for (int i = 7; i >= -1; i--) begin
         o_scl = 1'b0;
         #50;
         o_sda_oe = (i >= 0) ? ~b[i] : 1'b0;
         #50;
         o_scl = 1'b1;
         #100;
         if (i < 0) acked = ~i_sda_line;
      end
      o_scl = 1'b0;
      #50;
      o_sda_oe = 1'b1;
      #50;
      o_scl = 1'b1;
      #100;
      o_sda_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### dv/sensor_power_state_sequencer_tb.sv
// self-checking bench of the power state sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sensor_power_regs.svh"

module sensor_power_state_sequencer_tb;
   localparam int INIT = 200;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, irq = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, sda_out, sda_oe;
   logic        scl, host_oe, acked, init_busy, awake, osc_run, osc_tick, als_run, flk_run;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, rd;
   logic [31:0] x = 32'haa00fb24;
   wire logic   sda_line = ~(host_oe | (sda_oe & ~sda_out));
   int          failures = 0, checks = 0, cyc = 0, awake_cnt = 0, en = 0, n;
   int          seq[5] = '{3, 2, 1, 65, 67};

   always #12.5 clk = ~clk;

   sensor_power_state_sequencer #(.INIT_CYCLES(INIT)) u_dut (
      .i_clk_sys(clk), .i_nrst(nrst),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_irq_event(irq), .o_init_busy(init_busy), .o_bus_if_awake(awake),
      .o_osc_run(osc_run), .o_osc_tick(osc_tick), .o_als_run(als_run), .o_flicker_run(flk_run)
   );

   sps_i2c_host u_host (.i_sda_line(sda_line), .o_scl(scl), .o_sda_oe(host_oe));

   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (awake) awake_cnt <= awake_cnt + 1;
      if (cyc == 8000) begin
         failures++;
         wrap_up();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction

   function automatic logic [11:0] ad(input logic [9:0] i);
      return {i, 2'b00};
   endfunction

   function automatic logic [2:0] exp_st(input int e, input bit hold);
      if (hold) return sensor_power_pkg::ST_HOLD;
      if (!e[0]) return sensor_power_pkg::ST_SLEEP;
      if (e[1] || e[6]) return sensor_power_pkg::ST_ACTIVE;
      return sensor_power_pkg::ST_IDLE;
   endfunction

   // ==========================================================
   // axi4-lite master
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      check(32'(bresp), 32'(r));
   endtask

   task automatic rd_reg(input logic [11:0] a, input logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rd = rdata;
      check(32'(rresp), 32'(r));
   endtask

   task automatic set_en(input int e);
      en = e;
      wr(ad(`SPS_IDX_ENABLE), 32'(e), 2'b00);
   endtask

   task automatic chk_state(input bit hold);
      logic [2:0] s;
      s = exp_st(en, hold);
      repeat (4) @(posedge clk);
      rd_reg(ad(`SPS_IDX_STATE_VIEW), 2'b00);
      check(32'(rd[3:0]), 32'({s[1] & ~s[2], s}));
      check(32'({osc_run, als_run, flk_run}), 32'({s[1] & ~s[2], (s == 3'h2) & en[1], (s == 3'h2) & en[6]}));
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      u_host.frame(8'h52, acked);
      check(32'({acked, init_busy}), 32'h1);
      check(32'(awake_cnt), 32'h0);
      rd_reg(ad(`SPS_IDX_CFG0), 2'b00);
      check(rd, 32'(`SPS_CFG0_RST));
      rd_reg(ad(`SPS_IDX_STATE_VIEW), 2'b00);
      check(32'(rd[2:0]), 32'(sensor_power_pkg::ST_INIT));
      repeat (INIT) if (init_busy) @(posedge clk); // host holds off until ready
      check(32'(init_busy), 32'h0);
      chk_state(1'b0);
      u_host.frame(8'h52, acked);
      repeat (6) @(posedge clk);
      check(32'({awake_cnt > 95 && awake_cnt < 112, awake, acked}), 32'h4);
      chk_state(1'b0);
      set_en(1);
      chk_state(1'b0);
      n = 0;
      while (!osc_tick && n < 100) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!osc_tick && n < 100);
      check(32'(n), 32'(`SPS_OSC_DIV));
      for (int i = 0; i < 16; i++) begin
         x = xs(x);
         set_en(i < 5 ? seq[i] : int'(x & 32'h43));
         chk_state(1'b0);
      end
      set_en(3);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      chk_state(1'b0);
      wr(ad(`SPS_IDX_CFG0), 32'h48, 2'b00);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      chk_state(1'b1);
      rd_reg(ad(`SPS_IDX_STATUS4), 2'b00);
      check(32'(rd[0]), 32'h1);
      rd_reg(ad(`SPS_IDX_ENABLE), 2'b00);
      check(rd, 32'h3);
      wr(ad(`SPS_IDX_CONTROL), 32'h4, 2'b00);
      chk_state(1'b0);
      rd_reg(ad(`SPS_IDX_STATUS4), 2'b00);
      check(32'(rd[0]), 32'h0);
      wr(12'h004, 32'h0, 2'b10);
      rd_reg(12'h202, 2'b10);
      check(rd, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
